// [logic/swe_pkg.sv]
package swe_pkg;

	// Identity-selection commands
	localparam logic [7:0] CMD_READ_ID = 8'h33;
	localparam logic [7:0] CMD_MATCH_ID = 8'h55;
	localparam logic [7:0] CMD_BYPASS_ID = 8'hCC;
	localparam logic [7:0] CMD_SEARCH_ID = 8'hF0;
	// Memory commands and their key bytes
	localparam logic [7:0] CMD_FILL_SP = 8'h0F;
	localparam logic [7:0] CMD_READ_SP = 8'hAA;
	localparam logic [7:0] CMD_COMMIT_SP = 8'h55;
	localparam logic [7:0] CMD_FETCH_MEM = 8'hF0;
	localparam logic [7:0] CMD_FILL_AR = 8'h99;
	localparam logic [7:0] CMD_READ_STAT = 8'h66;
	localparam logic [7:0] CMD_READ_AR = 8'hC3;
	localparam logic [7:0] CMD_LOCK_AR = 8'h5A;
	localparam logic [7:0] KEY_COPY = 8'hA5;
	localparam logic [7:0] KEY_STATUS = 8'h00;

	localparam int DATA_BYTES = 32;
	localparam int AR_BYTES = 8;
	localparam logic [7:0] STATUS_FREE = 8'hFF;
	localparam logic [7:0] STATUS_LOCK_MASK = 8'hFC;
	localparam logic [7:0] CRC_FB_MASK = 8'h8C;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [5:0] ID_LAST = 6'h3F;
	localparam logic [7:0] BYTE_RELEASE = 8'hFF;

	// Timing at the core clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int COMMIT_TIME_NS = 10_000_000;
	localparam int SLOT_TIME_NS = 61_000;
	localparam int RESET_TIME_NS = 480_000;
	localparam int COMMIT_CYC = (COMMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOT_CYC = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_CYC = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Controller register map and fields
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CRC_CLR = 8'h08;
	localparam int CMD_DATA_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_PRESENCE = 1;
	localparam int STAT_CRC_ZERO = 2;
	localparam int STAT_RX_LSB = 8;
	localparam logic [2:0] OP_RESET = 3'h1;
	localparam logic [2:0] OP_TX_BYTE = 3'h2;
	localparam logic [2:0] OP_RX_BYTE = 3'h3;
	localparam logic [2:0] OP_TX_BIT = 3'h4;
	localparam logic [2:0] OP_RX_BIT = 3'h5;
	localparam logic [2:0] OP_HOLD = 3'h6;

	function automatic logic [7:0] swe_crc_step(input logic [7:0] crc, input logic b);
		logic fb;
		fb = crc[0] ^ b;
		swe_crc_step = {1'b0, crc[7:1]} ^ (fb ? CRC_FB_MASK : 8'h00);
	endfunction : swe_crc_step

	function automatic logic [7:0] swe_crc_calc(input logic [55:0] bits);
		logic [7:0] crc;
		crc = 8'h00;
		for (int i = 0; i < 56; i++) begin
			crc = swe_crc_step(crc, bits[i]);
		end
		swe_crc_calc = crc;
	endfunction : swe_crc_calc

endpackage : swe_pkg

// [logic/swe_link_if.sv]
`timescale 1ns/1ns
interface swe_link_if;
	logic bus_reset;
	logic presence;
	logic slot;
	logic master_bit;
	logic device_bit;
	logic line;

	// Open-drain wired-AND: either end pulling low wins
	assign line = master_bit & device_bit;

	modport host (
		output bus_reset,
		output slot,
		output master_bit,
		input presence,
		input line
	);
	modport device (
		input bus_reset,
		input slot,
		input line,
		output presence,
		output device_bit
	);
endinterface : swe_link_if

// [logic/swe_device.sv]
`timescale 1ns/1ns
module swe_device
	import swe_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE = 8'h3C, // Arbitrary value
	parameter logic [47:0] SERIAL_NUM = 48'h0000_1234_5678, // Arbitrary value
	parameter int COMMIT_CYCLES = COMMIT_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	swe_link_if.device link,
	output logic [7:0] otp_lock_status_out,
	output logic commit_busy_out
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_ID_CMD, ST_READ_ID, ST_MATCH, ST_SEARCH, ST_MEM_CMD,
		ST_ADDR, ST_WRITE, ST_READ, ST_KEY, ST_COMMIT
	} swe_dev_state_t;

	swe_dev_state_t state;
	logic [7:0] cmd;
	logic [2:0] bit_cnt;
	logic [7:0] rx_sr;
	logic [7:0] tx_sr;
	logic [5:0] id_idx;
	logic [1:0] srch_ph;
	logic [4:0] addr;
	logic [31:0] wait_cnt;
	logic [7:0] lock_status;
	logic [7:0] data_mem [DATA_BYTES];
	logic [7:0] data_sp [DATA_BYTES];
	logic [7:0] app_reg [AR_BYTES];
	logic [7:0] reg_sp [AR_BYTES];

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	logic [63:0] id_code;
	logic [7:0] rx_byte;
	logic byte_st;
	logic byte_done;
	logic ar_cmd;
	logic locked;
	logic [4:0] addr_rx;
	logic [7:0] rd_first;
	logic [7:0] rd_next;
	logic copy_go;
	logic lock_go;
	logic fetch_go;

	assign id_code = {swe_crc_calc({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM, FAMILY_CODE};
	assign rx_byte = {link.line, rx_sr[7:1]};
	assign byte_st = (state == ST_ID_CMD) || (state == ST_MEM_CMD) || (state == ST_ADDR) ||
		(state == ST_WRITE) || (state == ST_READ) || (state == ST_KEY);
	assign byte_done = link.slot && byte_st && (bit_cnt == BIT_LAST);
	assign ar_cmd = (cmd == CMD_FILL_AR) || (cmd == CMD_READ_AR);
	assign locked = (lock_status != STATUS_FREE);
	assign addr_rx = ar_cmd ? {2'b00, rx_byte[2:0]} : rx_byte[4:0];
	assign copy_go = (state == ST_KEY) && byte_done && (cmd == CMD_COMMIT_SP) &&
		(rx_byte == KEY_COPY);
	assign lock_go = (state == ST_KEY) && byte_done && (cmd == CMD_LOCK_AR) &&
		(rx_byte == KEY_COPY) && !locked;
	assign fetch_go = (state == ST_MEM_CMD) && byte_done && (rx_byte == CMD_FETCH_MEM);

	// Register-block pointer wraps at 07h, data pointer at 1Fh by its width
	function automatic logic [4:0] next_addr(input logic [4:0] a, input logic ar);
		logic [4:0] n;
		n = 5'(a + 5'h01);
		next_addr = ar ? {2'b00, n[2:0]} : n;
	endfunction : next_addr

	function automatic logic [7:0] rd_byte(input logic [4:0] a);
		if (cmd == CMD_READ_STAT) begin
			rd_byte = lock_status;
		end else if (cmd == CMD_READ_AR) begin
			// Once locked the scratchpad is hidden and the register itself shows
			rd_byte = locked ? app_reg[a[2:0]] : reg_sp[a[2:0]];
		end else begin
			rd_byte = data_sp[a];
		end
	endfunction : rd_byte

	// Procedural so that scratchpad, register and status updates re-evaluate the read bytes
	always_comb begin
		rd_first = rd_byte(addr_rx);
		rd_next = rd_byte(next_addr(addr, ar_cmd));
	end
	assign otp_lock_status_out = lock_status;

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			cmd <= '0;
			bit_cnt <= '0;
			rx_sr <= '0;
			tx_sr <= '1;
			id_idx <= '0;
			srch_ph <= '0;
			addr <= '0;
			wait_cnt <= '0;
			link.device_bit <= 1'b1;
			link.presence <= 1'b0;
			commit_busy_out <= 1'b0;
		end else if (link.bus_reset && state != ST_COMMIT) begin
			state <= ST_ID_CMD;
			link.presence <= 1'b1;
			bit_cnt <= '0;
			id_idx <= '0;
			srch_ph <= '0;
			link.device_bit <= 1'b1;
		end else begin
			link.presence <= 1'b0;
			if (link.slot && byte_st) begin
				bit_cnt <= 3'(bit_cnt + 3'h1);
				rx_sr <= rx_byte;
			end
			case (state)
				ST_ID_CMD: begin
					if (byte_done) begin
						if (rx_byte == CMD_READ_ID) begin
							state <= ST_READ_ID;
							link.device_bit <= id_code[0];
						end else if (rx_byte == CMD_MATCH_ID) begin
							state <= ST_MATCH;
						end else if (rx_byte == CMD_BYPASS_ID) begin
							state <= ST_MEM_CMD;
						end else if (rx_byte == CMD_SEARCH_ID) begin
							state <= ST_SEARCH;
							link.device_bit <= id_code[0];
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_READ_ID: begin
					if (link.slot) begin
						id_idx <= 6'(id_idx + 6'h01);
						if (id_idx == ID_LAST) begin
							state <= ST_MEM_CMD;
							link.device_bit <= 1'b1;
						end else begin
							link.device_bit <= id_code[6'(id_idx + 6'h01)];
						end
					end
				end
				ST_MATCH: begin
					if (link.slot) begin
						id_idx <= 6'(id_idx + 6'h01);
						if (link.line != id_code[id_idx]) begin
							state <= ST_IDLE;
						end else if (id_idx == ID_LAST) begin
							state <= ST_MEM_CMD;
						end
					end
				end
				ST_SEARCH: begin
					// Three slots per bit: true bit, complement, master's choice
					if (link.slot) begin
						if (srch_ph == 2'h0) begin
							srch_ph <= 2'h1;
							link.device_bit <= ~id_code[id_idx];
						end else if (srch_ph == 2'h1) begin
							srch_ph <= 2'h2;
							link.device_bit <= 1'b1;
						end else begin
							srch_ph <= 2'h0;
							id_idx <= 6'(id_idx + 6'h01);
							if (link.line != id_code[id_idx]) begin
								state <= ST_IDLE;
							end else if (id_idx == ID_LAST) begin
								state <= ST_MEM_CMD;
							end else begin
								link.device_bit <= id_code[6'(id_idx + 6'h01)];
							end
						end
					end
				end
				ST_MEM_CMD: begin
					if (byte_done) begin
						cmd <= rx_byte;
						if (rx_byte == CMD_FILL_SP || rx_byte == CMD_READ_SP ||
							rx_byte == CMD_FETCH_MEM || rx_byte == CMD_FILL_AR ||
							rx_byte == CMD_READ_AR) begin
							state <= ST_ADDR;
						end else if (rx_byte == CMD_COMMIT_SP || rx_byte == CMD_LOCK_AR ||
							rx_byte == CMD_READ_STAT) begin
							state <= ST_KEY;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						addr <= addr_rx;
						if (cmd == CMD_FILL_SP || cmd == CMD_FILL_AR) begin
							state <= ST_WRITE;
						end else begin
							state <= ST_READ;
							tx_sr <= rd_first;
							link.device_bit <= rd_first[0];
						end
					end
				end
				ST_WRITE: begin
					if (byte_done) begin
						addr <= next_addr(addr, ar_cmd);
					end
				end
				ST_READ: begin
					if (link.slot) begin
						if (bit_cnt == BIT_LAST) begin
							addr <= next_addr(addr, ar_cmd);
							tx_sr <= rd_next;
							link.device_bit <= rd_next[0];
						end else begin
							tx_sr <= {1'b1, tx_sr[7:1]};
							link.device_bit <= tx_sr[1];
						end
					end
				end
				ST_KEY: begin
					if (byte_done) begin
						if (copy_go) begin
							state <= ST_COMMIT;
							wait_cnt <= '0;
							commit_busy_out <= 1'b1;
						end else if (cmd == CMD_READ_STAT && rx_byte == KEY_STATUS) begin
							state <= ST_READ;
							tx_sr <= lock_status;
							link.device_bit <= lock_status[0];
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_COMMIT: begin
					// Write time: slots and resets are not honoured until it ends
					if (wait_cnt == 32'(COMMIT_CYCLES - 1)) begin
						state <= ST_IDLE;
						commit_busy_out <= 1'b0;
					end else begin
						wait_cnt <= 32'(wait_cnt + 32'h0000_0001);
					end
				end
				default: begin
					link.device_bit <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Storage

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DATA_BYTES; i++) begin
				data_mem[i] <= '0;
				data_sp[i] <= '0;
			end
			for (int i = 0; i < AR_BYTES; i++) begin
				app_reg[i] <= '0;
				reg_sp[i] <= '0;
			end
		end else begin
			if (state == ST_WRITE && byte_done && !link.bus_reset) begin
				if (cmd == CMD_FILL_SP) begin
					data_sp[addr] <= rx_byte;
				end else if (!locked) begin
					reg_sp[addr[2:0]] <= rx_byte;
				end
			end
			for (int i = 0; i < DATA_BYTES; i++) begin
				if (copy_go) begin
					data_mem[i] <= data_sp[i];
				end else if (fetch_go) begin
					data_sp[i] <= data_mem[i];
				end
			end
			for (int i = 0; i < AR_BYTES; i++) begin
				if (lock_go) begin
					app_reg[i] <= reg_sp[i];
				end
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			lock_status <= STATUS_FREE;
		end else if (lock_go) begin
			lock_status <= lock_status & STATUS_LOCK_MASK;
		end
	end

endmodule : swe_device

// [logic/swe_host.sv]
`timescale 1ns/1ns
module swe_host
	import swe_pkg::*;
#(
	parameter int SLOT_CYCLES = SLOT_CYC,
	parameter int RESET_CYCLES = RESET_CYC,
	parameter int COMMIT_CYCLES = COMMIT_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	swe_link_if.host link
);

	typedef enum logic [2:0] {H_IDLE, H_RESET, H_SLOT, H_GAP, H_HOLD} swe_host_state_t;

	swe_host_state_t state;
	logic [7:0] sh;
	logic [7:0] rx_sr;
	logic [3:0] bits_left;
	logic [31:0] cnt;
	logic pres_seen;
	logic rx_op;
	logic [7:0] crc;
	logic cmd_wr;
	logic [2:0] cmd_op;
	logic [7:0] cmd_data;
	logic [31:0] status_word;

	// Commands written while busy are dropped; software polls the busy bit
	assign cmd_wr = reg_wr_in && (reg_addr_in == REG_CMD) && (state == H_IDLE);
	assign cmd_op = reg_wdata_in[2:0];
	assign cmd_data = reg_wdata_in[CMD_DATA_LSB +: 8];

	always_comb begin
		status_word = '0;
		status_word[STAT_BUSY] = (state != H_IDLE);
		status_word[STAT_PRESENCE] = pres_seen;
		status_word[STAT_CRC_ZERO] = (crc == 8'h00);
		status_word[STAT_RX_LSB +: 8] = rx_sr;
	end

	////////////////////////////////////////////////////////////////////////////
	// Slot sequencer

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state <= H_IDLE;
			sh <= BYTE_RELEASE;
			rx_sr <= '0;
			bits_left <= '0;
			cnt <= '0;
			pres_seen <= 1'b0;
			rx_op <= 1'b0;
			link.bus_reset <= 1'b0;
			link.slot <= 1'b0;
			link.master_bit <= 1'b1;
		end else begin
			link.bus_reset <= 1'b0;
			link.slot <= 1'b0;
			case (state)
				H_IDLE: begin
					cnt <= '0;
					if (cmd_wr) begin
						if (cmd_op == OP_RESET) begin
							link.bus_reset <= 1'b1;
							pres_seen <= 1'b0;
							state <= H_RESET;
						end else if (cmd_op == OP_TX_BYTE || cmd_op == OP_RX_BYTE) begin
							sh <= (cmd_op == OP_RX_BYTE) ? BYTE_RELEASE : cmd_data;
							bits_left <= 4'h8;
							rx_op <= (cmd_op == OP_RX_BYTE);
							state <= H_SLOT;
						end else if (cmd_op == OP_TX_BIT || cmd_op == OP_RX_BIT) begin
							sh <= (cmd_op == OP_RX_BIT) ? BYTE_RELEASE : {7'h7F, cmd_data[0]};
							bits_left <= 4'h1;
							rx_op <= (cmd_op == OP_RX_BIT);
							state <= H_SLOT;
						end else if (cmd_op == OP_HOLD) begin
							state <= H_HOLD;
						end
					end
				end
				H_RESET: begin
					if (link.presence) begin
						pres_seen <= 1'b1;
					end
					if (cnt == 32'(RESET_CYCLES - 1)) begin
						state <= H_IDLE;
					end else begin
						cnt <= 32'(cnt + 32'h0000_0001);
					end
				end
				H_SLOT: begin
					link.master_bit <= sh[0];
					link.slot <= 1'b1;
					sh <= {1'b1, sh[7:1]};
					bits_left <= 4'(bits_left - 4'h1);
					cnt <= '0;
					state <= H_GAP;
				end
				H_GAP: begin
					if (link.slot) begin
						rx_sr <= {link.line, rx_sr[7:1]};
					end
					if (cnt == 32'(SLOT_CYCLES - 1)) begin
						link.master_bit <= 1'b1;
						state <= (bits_left == 4'h0) ? H_IDLE : H_SLOT;
					end else begin
						cnt <= 32'(cnt + 32'h0000_0001);
					end
				end
				H_HOLD: begin
					// Line left released, no slot or reset while EEPROM writes
					if (cnt == 32'(COMMIT_CYCLES - 1)) begin
						state <= H_IDLE;
					end else begin
						cnt <= 32'(cnt + 32'h0000_0001);
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			crc <= '0;
		end else if (state == H_GAP && link.slot && rx_op) begin
			crc <= swe_crc_step(crc, link.line);
		end else if (reg_wr_in && reg_addr_in == REG_CRC_CLR) begin
			crc <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in && reg_addr_in == REG_STATUS) begin
			reg_rdata_out <= status_word;
		end else begin
			reg_rdata_out <= '0;
		end
	end

endmodule : swe_host

// [sim/swe_checker.sv]
`timescale 1ns/1ns
module swe_checker #(
	parameter int COMMIT_CYCLES = 50
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic bus_reset,
	input wire logic presence,
	input wire logic slot,
	input wire logic device_bit,
	input wire logic [7:0] otp_lock_status_out,
	input wire logic commit_busy_out
);
	int busy_cnt;

	// Length of the current write time, checked when busy drops
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !commit_busy_out) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_bus_reset;
		bus_reset && !commit_busy_out;
	endsequence
	sequence s_presence;
		presence ##1 !presence;
	endsequence

	AST_PRESENCE_ANSWER: assert property (s_bus_reset |=> s_presence)
		else $error("no presence after bus reset");
	AST_PRESENCE_CAUSE: assert property (presence |-> $past(bus_reset))
		else $error("presence without bus reset");
	AST_RESET_PULSE: assert property (bus_reset |=> !bus_reset && !slot)
		else $error("bus reset pulse too long");
	AST_BUSY_IGNORES_RESET: assert property (commit_busy_out && bus_reset |=> !presence)
		else $error("presence during write time");
	AST_BUSY_FROM_SLOT: assert property ($rose(commit_busy_out) |-> $past(slot))
		else $error("write time began outside a slot");
	AST_BUSY_LENGTH: assert property ($fell(commit_busy_out) && !$past(rst_in) |->
		busy_cnt >= COMMIT_CYCLES && busy_cnt <= COMMIT_CYCLES + 1)
		else $error("write time length wrong");
	AST_RELEASED_BUSY: assert property (commit_busy_out |-> device_bit)
		else $error("device drives line during write time");
	AST_DEVBIT_AT_SLOT: assert property (!$stable(device_bit) |-> $past(slot) || $past(bus_reset))
		else $error("device bit moved between slots");
	AST_STATUS_CODES: assert property (otp_lock_status_out inside {8'hFF, 8'hFC})
		else $error("lock status value illegal");
	AST_LOCK_STICKS: assert property ($past(otp_lock_status_out) == 8'hFC |->
		otp_lock_status_out == 8'hFC)
		else $error("lock status left locked state");
endmodule : swe_checker

// [sim/swe_bench.sv]
`timescale 1ns/1ns
module swe_bench;
	import swe_pkg::*;
	localparam logic [7:0] FAM = 8'h5D; // Arbitrary value
	localparam logic [47:0] SER = 48'h0000_00A1_B2C3; // Arbitrary value
	localparam int CC = 50;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0000_0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic [7:0] otp_lock_status_out;
	logic commit_busy_out;
	logic [31:0] rv;
	logic [7:0] crc;
	logic [7:0] sh = 8'h00;
	logic [55:0] idv = {SER, FAM};
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	swe_link_if link();
	swe_device #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .COMMIT_CYCLES(CC)) u_swe_device (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .link(link),
		.otp_lock_status_out(otp_lock_status_out), .commit_busy_out(commit_busy_out));
	swe_host #(.SLOT_CYCLES(4), .RESET_CYCLES(4), .COMMIT_CYCLES(CC)) u_swe_host (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .link(link));
	swe_checker #(.COMMIT_CYCLES(CC)) u_swe_checker (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .bus_reset(link.bus_reset),
		.presence(link.presence), .slot(link.slot), .device_bit(link.device_bit),
		.otp_lock_status_out(otp_lock_status_out), .commit_busy_out(commit_busy_out));

	always #4 core_clk_in = ~core_clk_in;

	// Wire level at each slot, shifted in as it travels
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (link.slot) begin
			sh <= {link.line, sh[7:1]};
		end
		if (cyc == 40000) begin
			errors++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [7:0] step(input logic [7:0] c, input logic b);
		step = {1'b0, c[7:1]} ^ ((c[0] ^ b) ? 8'h8C : 8'h00);
	endfunction : step

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 rv = reg_rdata_out;
	endtask : rd

	// Busy is polled under a bound so a stuck controller cannot hang the run
	task automatic op(input logic [2:0] o, input logic [7:0] d);
		wr(REG_CMD, {16'h0000, d, 5'h00, o});
		rd(REG_STATUS);
		for (int i = 0; i < 300 && rv[STAT_BUSY] !== 1'b0; i++) rd(REG_STATUS);
	endtask : op

	task automatic tx(input logic [7:0] b);
		op(OP_TX_BYTE, b);
	endtask : tx

	task automatic rxc(input logic [7:0] e);
		op(OP_RX_BYTE, 8'hFF);
		check(rv[15:8], e);
	endtask : rxc

	task automatic brst(input logic p);
		op(OP_RESET, 8'h00);
		check(rv[STAT_PRESENCE], p);
	endtask : brst

	task automatic sel();
		brst(1'b1);
		tx(CMD_BYPASS_ID);
	endtask : sel

	task automatic fill(input logic [7:0] a, input logic [23:0] d);
		sel();
		tx(CMD_FILL_SP);
		tx(a);
		for (int i = 0; i < 3; i++) tx(d[8*i +: 8]);
	endtask : fill

	task automatic stream(input logic [7:0] c, input logic [7:0] a, input logic [23:0] e);
		sel();
		tx(c);
		tx(a);
		for (int i = 0; i < 3; i++) rxc(e[8*i +: 8]);
	endtask : stream

	task automatic match(input logic [7:0] flip, input logic [7:0] e);
		brst(1'b1);
		tx(CMD_MATCH_ID);
		for (int i = 0; i < 7; i++) tx(idv[8*i +: 8] ^ (i == 0 ? flip : 8'h00));
		tx(crc);
		tx(CMD_READ_SP);
		tx(8'h1E);
		rxc(e);
	endtask : match

	// Three slots per identity bit: true bit, complement, then the master's choice
	task automatic search_id();
		logic [63:0] full_id;
		full_id = {crc, idv};
		brst(1'b1);
		tx(CMD_SEARCH_ID);
		for (int i = 0; i < 64; i++) begin
			op(OP_RX_BIT, 8'hFF);
			check(rv[15], full_id[i]);
			op(OP_RX_BIT, 8'hFF);
			check(rv[15], !full_id[i]);
			op(OP_TX_BIT, {7'h00, full_id[i]});
		end
		tx(CMD_READ_SP);
		tx(8'h1E);
		rxc(8'h11);
	endtask : search_id

	task automatic wait_idle();
		for (int i = 0; i < 200 && commit_busy_out !== 1'b0; i++) @(posedge core_clk_in);
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		check(otp_lock_status_out, 8'hFF);
		crc = 8'h00;
		for (int i = 0; i < 56; i++) crc = step(crc, idv[i]);
		brst(1'b1);
		tx(CMD_READ_ID);
		check(sh, 8'h33);
		wr(REG_CRC_CLR, 32'h0000_0000);
		for (int i = 0; i < 7; i++) rxc(idv[8*i +: 8]);
		rxc(crc);
		check(rv[STAT_CRC_ZERO], 1'b1);
		check(sh, crc);
		fill(8'h1E, 24'h33_2211);
		stream(CMD_READ_SP, 8'h1E, 24'h33_2211);
		sel();
		tx(CMD_COMMIT_SP);
		tx(KEY_COPY);
		check(commit_busy_out, 1'b1);
		brst(1'b0);
		wait_idle();
		fill(8'h1E, 24'h66_5544);
		sel();
		tx(CMD_COMMIT_SP);
		tx(8'h5A);
		check(commit_busy_out, 1'b0);
		stream(CMD_FETCH_MEM, 8'h1E, 24'h33_2211);
		fill(8'h1E, 24'h66_5544);
		sel();
		tx(CMD_FETCH_MEM);
		stream(CMD_READ_SP, 8'h1E, 24'h33_2211);
		fill(8'h00, 24'h99_8877);
		sel();
		tx(CMD_COMMIT_SP);
		tx(KEY_COPY);
		op(OP_HOLD, 8'h00);
		check(commit_busy_out, 1'b0);
		stream(CMD_FETCH_MEM, 8'h1E, 24'h77_2211);
		match(8'h00, 8'h11);
		match(8'h01, 8'hFF);
		search_id();
		sel();
		tx(8'h12);
		rxc(8'hFF);
		brst(1'b1);
		tx(CMD_READ_SP);
		tx(8'h1E);
		rxc(8'hFF);
		sel();
		tx(CMD_READ_STAT);
		tx(KEY_STATUS);
		rxc(8'hFF);
		sel();
		tx(CMD_FILL_AR);
		tx(8'h07);
		tx(8'hAB);
		tx(8'hCD);
		stream(CMD_READ_AR, 8'h07, 24'h00_CDAB);
		for (int k = 0; k < 2; k++) begin
			sel();
			tx(CMD_LOCK_AR);
			tx(KEY_COPY);
			wait_idle();
			check(otp_lock_status_out, 8'hFC);
		end
		sel();
		tx(CMD_FILL_AR);
		tx(8'h07);
		tx(8'h12);
		stream(CMD_READ_AR, 8'h07, 24'h00_CDAB);
		sel();
		tx(CMD_READ_STAT);
		tx(KEY_STATUS);
		rxc(8'hFC);
		rd(8'h0C);
		check(rv, 32'h0000_0000);
		rd(REG_CMD);
		check(rv, 32'h0000_0000);
		@(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		check(otp_lock_status_out, 8'hFF);
		print_verdict();
	end
endmodule : swe_bench
